// file: flash_write_erase_sequencer.sv
// Flash write and page erase sequencer with byte gathering and DMA request.
// Operation
// - Request DMA whenever port can accept another byte
// - Starting write with armed DMA requests first byte
// - Program one 32-bit word per four bytes
// - Word busy flag held while word programs
// - Erased page reads all ones
// - Erase bit erases page from high address
// - Erase together with write: erase first
// - Busy flag covers whole erase, then clears unless a write is pending
// - Fetch from flash stalls until operation ends
// - Control value 02h starts a write
// - Control value 01h starts a page erase
// - Write port also at external address DFAFh
// - Start address is high:low; word busy during program
// - Status bits 7 and 6 read-only, reset zero
// - Timing value resets to 2Ah
`timescale 1ns/1ps
`default_nettype none
module flash_write_erase_sequencer
#(
   parameter int ERASE_TICKS = flash_seq_pkg::ERASE_TICKS_DEF
)
(
   input  wire logic                      CLK,
   input  wire logic                      ARST_N,
   input  wire flash_seq_pkg::sfr_wr_s    SFR_WR,
   input  wire flash_seq_pkg::xdata_wr_s  XDATA_WR,
   input  wire logic                      RUN_FROM_FLASH,
   output var  logic [7:0]                CONTROL_STATUS,
   output var  logic [7:0]                ADDR_HIGH,
   output var  logic [7:0]                ADDR_LOW,
   output var  logic [5:0]                TIMING_VALUE,
   output var  logic                      DMA_REQ,
   output var  logic                      FETCH_STALL,
   output var  flash_seq_pkg::array_cmd_s ARRAY_CMD
);

   localparam logic [15:0] WRITE_TICKS_C = 16'(flash_seq_pkg::WRITE_TICKS);
   localparam logic [15:0] ERASE_TICKS_C = 16'(ERASE_TICKS);

   // A byte reaches the write data port through either address map.
   function automatic logic port_hit(input flash_seq_pkg::sfr_wr_s s,
                                     input flash_seq_pkg::xdata_wr_s x);
      port_hit = s.data_we ||
                 (x.we && x.addr == flash_seq_pkg::XDATA_PORT_ADDR);
   endfunction

   function automatic logic [7:0] port_byte(input flash_seq_pkg::sfr_wr_s s);
      port_byte = s.data_we ? s.wdata : XDATA_WR.wdata;
   endfunction

   // Software-written registers.
   logic [7:0] addr_hi_reg;
   logic [7:0] addr_hi_next;
   logic [7:0] addr_lo_reg;
   logic [7:0] addr_lo_next;
   logic [5:0] timing_reg;
   logic [5:0] timing_next;
   logic [3:0] spare_reg;
   logic [3:0] spare_next;

   // Sequencer state.
   flash_seq_pkg::seq_state_e  state_reg;
   flash_seq_pkg::seq_state_e  state_next;
   flash_seq_pkg::array_cmd_s  array_reg;
   flash_seq_pkg::array_cmd_s  array_next;
   logic [1:0]                 byte_cnt_reg;
   logic [1:0]                 byte_cnt_next;
   logic [15:0]                tick_cnt_reg;
   logic [15:0]                tick_cnt_next;
   logic                       pend_write_reg;
   logic                       pend_write_next;
   logic                       from_flash_reg;
   logic                       from_flash_next;
   logic                       dma_req_reg;
   logic                       dma_req_next;
   logic                       stall_reg;
   logic                       stall_next;
   logic [7:0]                 status_reg;
   logic [7:0]                 status_next;
   logic                       tick;
   logic                       byte_in;
   logic [14:0]                start_addr;

   assign byte_in    = port_hit(SFR_WR, XDATA_WR);
   assign start_addr = {addr_hi_reg[6:0], addr_lo_reg};

   flash_timing_tick u_tick
   (
      .CLK    (CLK),
      .ARST_N (ARST_N),
      .RUN    (state_reg == flash_seq_pkg::ST_ERASE ||
               state_reg == flash_seq_pkg::ST_PROG),
      .PERIOD (timing_reg),
      .TICK   (tick)
   );

   always_comb
   begin
      addr_hi_next = SFR_WR.addr_hi_we ? SFR_WR.wdata : addr_hi_reg;
      addr_lo_next = SFR_WR.addr_lo_we ? SFR_WR.wdata : addr_lo_reg;
      timing_next  = SFR_WR.timing_we  ? SFR_WR.wdata[5:0] : timing_reg;
      spare_next   = spare_reg;
      if (SFR_WR.ctrl_we)
      begin
         spare_next = SFR_WR.wdata[flash_seq_pkg::CTL_SPARE_MSB:
                                   flash_seq_pkg::CTL_SPARE_LSB];
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         addr_hi_reg <= flash_seq_pkg::ADDR_RESET;
         addr_lo_reg <= flash_seq_pkg::ADDR_RESET;
         timing_reg  <= flash_seq_pkg::TIMING_RESET;
         spare_reg   <= flash_seq_pkg::SPARE_RESET;
      end
      else
      begin
         addr_hi_reg <= addr_hi_next;
         addr_lo_reg <= addr_lo_next;
         timing_reg  <= timing_next;
         spare_reg   <= spare_next;
      end
   end

   // Control writes during an erase or a word program only update the spare bits; software
   // is expected to wait for the busy flag before reconfiguring.
   always_comb
   begin
      state_next      = state_reg;
      array_next      = array_reg;
      byte_cnt_next   = byte_cnt_reg;
      tick_cnt_next   = tick_cnt_reg;
      pend_write_next = pend_write_reg;
      from_flash_next = from_flash_reg;
      dma_req_next    = 1'b0;
      case (state_reg)
         flash_seq_pkg::ST_IDLE:
         begin
            if (SFR_WR.ctrl_we)
            begin
               pend_write_next = SFR_WR.wdata[flash_seq_pkg::CTL_WRITE_BIT];
               from_flash_next = RUN_FROM_FLASH;
               tick_cnt_next   = 16'h0000;
               if (SFR_WR.wdata[flash_seq_pkg::CTL_ERASE_BIT])
               begin
                  state_next       = flash_seq_pkg::ST_ERASE;
                  array_next.erase = 1'b1;
                  array_next.page  = addr_hi_reg[flash_seq_pkg::PAGE_MSB:
                                                 flash_seq_pkg::PAGE_LSB];
                  array_next.wdata = flash_seq_pkg::ERASED_WORD;
               end
               else if (SFR_WR.wdata[flash_seq_pkg::CTL_WRITE_BIT])
               begin
                  state_next           = flash_seq_pkg::ST_COLLECT;
                  array_next.word_addr = start_addr;
                  byte_cnt_next        = 2'h0;
                  dma_req_next         = 1'b1;
               end
            end
         end
         flash_seq_pkg::ST_ERASE:
         begin
            if (tick)
            begin
               tick_cnt_next = tick_cnt_reg + 16'h0001;
            end
            if (tick && tick_cnt_reg + 16'h0001 >= ERASE_TICKS_C)
            begin
               array_next.erase = 1'b0;
               if (pend_write_reg)
               begin
                  state_next           = flash_seq_pkg::ST_COLLECT;
                  array_next.word_addr = start_addr;
                  byte_cnt_next        = 2'h0;
                  dma_req_next         = 1'b1;
               end
               else
               begin
                  state_next = flash_seq_pkg::ST_IDLE;
               end
            end
         end
         flash_seq_pkg::ST_COLLECT:
         begin
            if (SFR_WR.ctrl_we && !SFR_WR.wdata[flash_seq_pkg::CTL_WRITE_BIT])
            begin
               state_next = flash_seq_pkg::ST_IDLE;
            end
            else if (byte_in)
            begin
               array_next.wdata[byte_cnt_reg*8 +: 8] = port_byte(SFR_WR);
               byte_cnt_next = byte_cnt_reg + 2'h1;
               if (byte_cnt_reg == flash_seq_pkg::LAST_BYTE)
               begin
                  state_next      = flash_seq_pkg::ST_PROG;
                  array_next.prog = 1'b1;
                  tick_cnt_next   = 16'h0000;
               end
               else
               begin
                  dma_req_next = 1'b1;
               end
            end
         end
         flash_seq_pkg::ST_PROG:
         begin
            if (tick)
            begin
               tick_cnt_next = tick_cnt_reg + 16'h0001;
            end
            if (tick && tick_cnt_reg + 16'h0001 >= WRITE_TICKS_C)
            begin
               array_next.prog      = 1'b0;
               array_next.word_addr = array_reg.word_addr + 15'h0001;
               state_next           = flash_seq_pkg::ST_COLLECT;
               dma_req_next         = 1'b1;
            end
         end
         default:
         begin
            state_next = flash_seq_pkg::ST_IDLE;
         end
      endcase
      stall_next = from_flash_next && (array_next.erase || array_next.prog);
      status_next = {state_next != flash_seq_pkg::ST_IDLE, array_next.prog,
                     spare_next,
                     state_next == flash_seq_pkg::ST_COLLECT ||
                     state_next == flash_seq_pkg::ST_PROG,
                     array_next.erase};
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_reg      <= flash_seq_pkg::ST_IDLE;
         array_reg      <= '0;
         byte_cnt_reg   <= 2'h0;
         tick_cnt_reg   <= 16'h0000;
         pend_write_reg <= 1'b0;
         from_flash_reg <= 1'b0;
         dma_req_reg    <= 1'b0;
         stall_reg      <= 1'b0;
         status_reg     <= flash_seq_pkg::CTL_RESET;
      end
      else
      begin
         state_reg      <= state_next;
         array_reg      <= array_next;
         byte_cnt_reg   <= byte_cnt_next;
         tick_cnt_reg   <= tick_cnt_next;
         pend_write_reg <= pend_write_next;
         from_flash_reg <= from_flash_next;
         dma_req_reg    <= dma_req_next;
         stall_reg      <= stall_next;
         status_reg     <= status_next;
      end
   end

   assign CONTROL_STATUS = status_reg;
   assign ADDR_HIGH      = addr_hi_reg;
   assign ADDR_LOW       = addr_lo_reg;
   assign TIMING_VALUE   = timing_reg;
   assign DMA_REQ        = dma_req_reg;
   assign FETCH_STALL    = stall_reg;
   assign ARRAY_CMD      = array_reg;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence seq_idle_ctrl;
      state_reg == flash_seq_pkg::ST_IDLE && SFR_WR.ctrl_we;
   endsequence

   sequence seq_write_start;
      seq_idle_ctrl ##0 SFR_WR.wdata[1:0] == 2'h2;
   endsequence

   sequence seq_erase_start;
      seq_idle_ctrl ##0 SFR_WR.wdata[0];
   endsequence

   sequence seq_mid_byte;
      state_reg == flash_seq_pkg::ST_COLLECT && byte_in && !SFR_WR.ctrl_we &&
      byte_cnt_reg != flash_seq_pkg::LAST_BYTE;
   endsequence

   chk_dma_on_start: assert property (seq_write_start |=> DMA_REQ ##1 !DMA_REQ)
      else $error("write start did not raise one DMA request");
   chk_dma_per_byte: assert property (seq_mid_byte |=> DMA_REQ)
      else $error("accepted byte not followed by DMA request");
   chk_xdata_port: assert property (seq_mid_byte ##0 !SFR_WR.data_we |=> DMA_REQ)
      else $error("external-space byte not taken by the port");
   chk_prog_fourth: assert property (state_reg == flash_seq_pkg::ST_COLLECT &&
      byte_in && !SFR_WR.ctrl_we && byte_cnt_reg == flash_seq_pkg::LAST_BYTE
      |=> ARRAY_CMD.prog && CONTROL_STATUS[6] && !DMA_REQ)
      else $error("fourth byte did not start word programming");
   chk_word_busy: assert property (ARRAY_CMD.prog |-> CONTROL_STATUS[6] &&
      CONTROL_STATUS[7])
      else $error("word busy flag low during programming");
   chk_erase_page: assert property (seq_erase_start |=> ARRAY_CMD.erase &&
      ARRAY_CMD.page == $past(addr_hi_reg[6:1]) &&
      ARRAY_CMD.wdata == flash_seq_pkg::ERASED_WORD)
      else $error("erase did not target the addressed page");
   chk_erase_first: assert property (seq_erase_start ##0 SFR_WR.wdata[1]
      |=> state_reg == flash_seq_pkg::ST_ERASE && !DMA_REQ)
      else $error("write began before the erase");
   chk_write_after: assert property ($fell(ARRAY_CMD.erase) && pend_write_reg
      |-> state_reg == flash_seq_pkg::ST_COLLECT && DMA_REQ)
      else $error("pending write did not follow the erase");
   chk_busy_erase: assert property (ARRAY_CMD.erase |-> CONTROL_STATUS[7])
      else $error("busy flag low during erase");
   chk_busy_clear: assert property ($fell(ARRAY_CMD.erase) && !pend_write_reg
      |-> !CONTROL_STATUS[7])
      else $error("busy flag stuck after erase");
   chk_addr_advance: assert property ($fell(ARRAY_CMD.prog) |->
      ARRAY_CMD.word_addr == $past(ARRAY_CMD.word_addr) + 15'h0001)
      else $error("word address did not advance");
   chk_fetch_stall: assert property ((ARRAY_CMD.erase || ARRAY_CMD.prog) &&
      from_flash_reg |-> FETCH_STALL)
      else $error("fetch not stalled during flash operation");

endmodule
`default_nettype wire

// file: flash_seq_pkg.sv
// Constants, field layout and carrier types of the flash write/erase sequencer.
package flash_seq_pkg;

   // Control/status byte layout.
   localparam int CTL_BUSY_BIT   = 7;
   localparam int CTL_WBUSY_BIT  = 6;
   localparam int CTL_SPARE_MSB  = 5;
   localparam int CTL_SPARE_LSB  = 2;
   localparam int CTL_WRITE_BIT  = 1;
   localparam int CTL_ERASE_BIT  = 0;
   localparam logic [7:0] CTL_RESET    = 8'h00;
   localparam logic [3:0] SPARE_RESET  = 4'h0;

   // Address registers and the page field inside the high byte.
   localparam logic [7:0] ADDR_RESET   = 8'h00;
   localparam int PAGE_MSB       = 6;
   localparam int PAGE_LSB       = 1;
   localparam int WORD_ADDR_W    = 15;
   localparam int PAGE_W         = PAGE_MSB - PAGE_LSB + 1;

   // Write data port alias in the external data space.
   localparam logic [15:0] XDATA_PORT_ADDR = 16'hDFAF;

   // Word gathering.
   localparam int BYTES_PER_WORD = 4;
   localparam logic [1:0] LAST_BYTE = 2'(BYTES_PER_WORD - 1);
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;

   // Timing value and the time base it produces.
   localparam logic [5:0] TIMING_RESET = 6'h2A;
   localparam longint REF_CLK_MHZ   = 32;
   localparam longint WRITE_TIME_NS = 20_000;
   localparam longint ERASE_TIME_MS = 20;
   // One timing tick lasts TIMING_RESET cycles of the reference clock.
   localparam longint TICK_PS = longint'(TIMING_RESET) * 1_000_000 / REF_CLK_MHZ;
   localparam int WRITE_TICKS =
      int'((WRITE_TIME_NS * 1000 + TICK_PS - 1) / TICK_PS);
   localparam int ERASE_TICKS_DEF =
      int'((ERASE_TIME_MS * 1_000_000_000 + TICK_PS - 1) / TICK_PS);
   localparam int TICK_CNT_W = 16;

   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_COLLECT, ST_PROG} seq_state_e;

   // Special-function register writes from the CPU, one strobe per register.
   typedef struct packed {
      logic       ctrl_we;
      logic       data_we;
      logic       addr_hi_we;
      logic       addr_lo_we;
      logic       timing_we;
      logic [7:0] wdata;
   } sfr_wr_s;

   // External data space write, as issued by the DMA channel or the CPU.
   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } xdata_wr_s;

   // Command to the flash array macro.
   typedef struct packed {
      logic                   prog;
      logic                   erase;
      logic [WORD_ADDR_W-1:0] word_addr;
      logic [PAGE_W-1:0]      page;
      logic [31:0]            wdata;
   } array_cmd_s;

endpackage

// file: flash_timing_tick.sv
// Time base that pulses once every timing-value clock cycles while running.
`timescale 1ns/1ps
`default_nettype none
module flash_timing_tick
(
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   input  wire logic       RUN,
   input  wire logic [5:0] PERIOD,
   output var  logic       TICK
);

   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic       tick_reg;
   logic       tick_next;

   // A period of zero is treated as one so the sequence can never hang.
   always_comb
   begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (!RUN)
      begin
         cnt_next = 6'h00;
      end
      else if (cnt_reg + 6'h01 >= PERIOD)
      begin
         cnt_next  = 6'h00;
         tick_next = 1'b1;
      end
      else
      begin
         cnt_next = cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cnt_reg  <= 6'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign TICK = tick_reg;

endmodule
`default_nettype wire

// file: flash_dma_model.sv
// Behavioural DMA channel that feeds the write data port on each request.
`timescale 1ns/1ps
`default_nettype none
module flash_dma_model
(
   input  wire logic                     CLK,
   input  wire logic                     ARMED,
   input  wire logic                     REQ,
   input  wire logic [7:0]               SRC_BASE,
   input  wire logic [3:0]               LAG,
   output var  flash_seq_pkg::xdata_wr_s XW
);
   logic [7:0] idx;

   initial
   begin
      XW  = '0;
      idx = 8'h00;
   end

   // Single request, one byte, incrementing source, fixed destination.
   always @(posedge CLK)
   begin
      if (!ARMED)
         idx = 8'h00;
      else if (REQ)
      begin
         repeat (LAG) @(posedge CLK);
         #1;
         XW.we    = 1'b1;
         XW.addr  = 16'hDFAF;
         XW.wdata = SRC_BASE + idx;
         @(posedge CLK);
         #1;
         // Released lines show the inverse so stale values never match.
         XW.we    = 1'b0;
         XW.addr  = ~XW.addr;
         XW.wdata = ~XW.wdata;
         idx      = idx + 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: flash_write_erase_sequencer_tb.sv
// Self-checking testbench of the flash write and page erase sequencer.
`timescale 1ns/1ps
`default_nettype none
module flash_write_erase_sequencer_tb;
   localparam logic [4:0] W_CTL = 5'b1_0000;
   localparam logic [4:0] W_DAT = 5'b0_1000;
   localparam logic [4:0] W_HI  = 5'b0_0100;
   localparam logic [4:0] W_LO  = 5'b0_0010;
   localparam logic [4:0] W_TIM = 5'b0_0001;
   logic                       clk = 1'b0;
   logic                       arst_n = 1'b0;
   flash_seq_pkg::sfr_wr_s     sfr = '0;
   flash_seq_pkg::xdata_wr_s   xw;
   flash_seq_pkg::array_cmd_s  cmd, e;
   flash_seq_pkg::array_cmd_s  exp_q[$];
   logic                       run_flash = 1'b0, armed = 1'b0;
   logic                       prog_d = 1'b0, erase_d = 1'b0, dreq, stall;
   logic [7:0]                 ctl, ahi, alo, hi, lo, sb = '0;
   logic [5:0]                 tv;
   logic [3:0]                 lag = '0;
   logic [14:0]                wa;
   logic [31:0]                d;
   int                         fail_count = 0, comparisons = 0, n;

   always #2.5 clk = ~clk;

   flash_write_erase_sequencer #(.ERASE_TICKS(4)) flash_write_erase_sequencer_i
   (
      .CLK(clk), .ARST_N(arst_n), .SFR_WR(sfr), .XDATA_WR(xw),
      .RUN_FROM_FLASH(run_flash), .CONTROL_STATUS(ctl), .ADDR_HIGH(ahi),
      .ADDR_LOW(alo), .TIMING_VALUE(tv), .DMA_REQ(dreq),
      .FETCH_STALL(stall), .ARRAY_CMD(cmd)
   );

   flash_dma_model flash_dma_model_i
   (
      .CLK(clk), .ARMED(armed), .REQ(dreq), .SRC_BASE(sb), .LAG(lag),
      .XW(xw)
   );

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] expd);
      comparisons++;
      if (seen !== expd)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [4:0] s, input logic [7:0] v);
      @(posedge clk);
      #1 sfr = {s, v};
      @(posedge clk);
      #1 sfr = '0;
   endtask

   // Bit 8 stands for the expectation queue still holding entries.
   task automatic settle(input int b, output int cnt);
      cnt = 0;
      while ((b < 8 ? ctl[b] : exp_q.size() != 0) && cnt < 1000)
      begin
         @(posedge clk);
         #1;
         cnt++;
      end
      if (cnt == 1000)
         check("wait bound", 1, 0);
   endtask

   task automatic expect_cmd(input logic er, input logic [31:0] v);
      e           = '0;
      e.erase     = er;
      e.prog      = !er;
      e.word_addr = wa;
      e.page      = hi[6:1];
      e.wdata     = v;
      exp_q.push_back(e);
   endtask

   // Each rising command to the array is matched against the oldest note.
   always @(posedge clk)
   begin
      prog_d  <= cmd.prog;
      erase_d <= cmd.erase;
      if (arst_n && ((cmd.prog && !prog_d) || (cmd.erase && !erase_d)))
      begin
         if (exp_q.size() == 0)
            check("unexpected array command", 1, 0);
         else
         begin
            e = exp_q.pop_front();
            check("erase first", cmd.erase, e.erase);
            if (e.erase)
            begin
               check("erase page", cmd.page, e.page);
               check("erase data", cmd.wdata, e.wdata);
            end
            else
            begin
               check("word address", cmd.word_addr, e.word_addr);
               check("word data", cmd.wdata, e.wdata);
               check("word busy", ctl[6], 1'b1);
               check("no request in program", dreq, 1'b0);
            end
         end
      end
   end

   initial
   begin
      #(5 * 20000);
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(32'h6130aa27));
      repeat (10) @(posedge clk);
      #1 arst_n = 1'b1;
      check("status reset", ctl, 8'h00);
      check("timing reset", tv, 6'h2A);
      // A short tick keeps the run brief; the fast bench clock stands in
      // for the reference clock here.
      wr(W_TIM, 8'h01);
      check("timing readback", tv, 6'h01);
      wr(W_CTL, 8'hFC);
      check("status read-only", ctl, 8'h3C);
      // Page erase started while code runs from flash.
      hi = 8'($urandom);
      lo = 8'($urandom);
      wr(W_HI, hi);
      wr(W_LO, lo);
      check("addr high readback", ahi, hi);
      check("addr low readback", alo, lo);
      run_flash = 1'b1;
      expect_cmd(1'b1, 32'hFFFF_FFFF);
      wr(W_CTL, 8'h01);
      check("erase busy", ctl[7], 1'b1);
      check("fetch stall", stall, 1'b1);
      settle(7, n);
      check("erase length", n >= 4, 1'b1);
      check("stall released", stall, 1'b0);
      // Two words fed by the DMA channel with a random lag.
      run_flash = 1'b0;
      hi = 8'($urandom);
      lo = 8'($urandom);
      wr(W_HI, hi);
      wr(W_LO, lo);
      sb = 8'($urandom);
      lag = 4'($urandom % 4);
      armed = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         wa = 15'({hi[6:0], lo} + k);
         for (int j = 0; j < 4; j++)
            d[8*j +: 8] = 8'(sb + 4 * k + j);
         expect_cmd(1'b0, d);
      end
      wr(W_CTL, 8'h02);
      check("first request", dreq, 1'b1);
      settle(8, n);
      settle(6, n);
      armed = 1'b0;
      wr(W_CTL, 8'h00);
      @(posedge clk);
      #1 check("write ended", ctl[7], 1'b0);
      // Erase and write together, bytes from the CPU; one is sent too early.
      hi = 8'($urandom);
      lo = 8'($urandom);
      wr(W_HI, hi);
      wr(W_LO, lo);
      wa = {hi[6:0], lo};
      d = $urandom;
      expect_cmd(1'b1, 32'hFFFF_FFFF);
      expect_cmd(1'b0, d);
      wr(W_CTL, 8'h03);
      wr(W_DAT, 8'hEE);
      settle(0, n);
      for (int j = 0; j < 4; j++)
         wr(W_DAT, d[8*j +: 8]);
      settle(8, n);
      settle(6, n);
      wr(W_CTL, 8'h00);
      settle(7, n);
      check("idle at end", ctl[7:6], 2'b00);
      tally_and_finish();
   end
endmodule
`default_nettype wire
